/* File: scd_clock_ctrl.sv */
// system clock selection, dividers, peripheral taps and crystal stop detect
`include "scd_map.svh"
`default_nettype none
module scd_clock_ctrl (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// oscillator inputs, asynchronous to sys_clk
	input  wire logic       main_crystal_clock,
	input  wire logic       sub_crystal_clock,
	input  wire logic       low_speed_osc_clock,
	input  wire logic       high_speed_osc_clock,
	input  wire logic       watchdog_osc_clock,
	// software write of the stateful control bits
	input  wire logic       ctl_wr,
	input  wire logic       wr_div8_select_bit,
	input  wire logic       wr_cpu_divider_low_bit,
	input  wire logic       wr_cpu_divider_high_bit,
	input  wire logic       wr_low_speed_osc_stop_bit,
	input  wire logic       wr_onchip_select_flag,
	input  wire logic       wr_crystal_stopped_flag,
	// plain control levels
	input  wire logic       sub_clock_select_bit,
	input  wire logic       main_crystal_stop_bit,
	input  wire logic       crystal_pin_mode_bit,
	input  wire logic       sub_crystal_stop_bit,
	input  wire logic       wake_divider_override_bit,
	input  wire logic       wait_gating_low_bit,
	input  wire logic       wait_gating_high_bit,
	input  wire logic       high_speed_osc_enable_bit,
	input  wire logic       onchip_osc_select_bit,
	input  wire logic [2:0] high_speed_divide_field,
	input  wire logic       div128_source_bit,
	input  wire logic       count_source_protection_bit,
	input  wire logic       detect_enable_low_bit,
	input  wire logic       detect_enable_high_bit,
	// power mode events from the power controller
	input  wire logic       wait_mode,
	input  wire logic       stop_enter,
	// generated clocks
	output logic            cpu_clock,
	output logic [4:0]      peripheral_divided_clock,
	output logic            general_onchip_clock,
	output logic            high_speed_timer_clock,
	output logic            fast_divided_onchip_clock,
	output logic            slow_onchip_clock,
	output logic            capture_div128_clock,
	output logic            watchdog_dedicated_clock,
	// status
	output logic            div8_select_bit,
	output logic            cpu_divider_low_bit,
	output logic            cpu_divider_high_bit,
	output logic            low_speed_osc_stop_bit,
	output logic            onchip_select_flag,
	output logic            crystal_stopped_flag,
	output logic            stop_detect_irq,
	output logic            port_pins_available
);

	scd_pkg::scd_state_t q;
	scd_pkg::scd_state_t d;

	logic [`SCD_NUM_CH-1:0] ch_src;
	logic [`SCD_NUM_CH-1:0] ch_run;
	logic [`SCD_NUM_CH-1:0] ch_out;
	logic [7:0]             ch_ratio [`SCD_NUM_CH];

	logic [1:0]             detect_field;
	logic [1:0]             gating_field;
	logic                   detect_on;
	logic                   main_rise;
	logic                   stop_fire;
	logic                   onchip_lvl;
	logic                   old_lvl;
	logic                   new_lvl;
	logic                   wait_rise;
	logic [7:0]             cpu_ratio;
	logic [7:0]             fast_ratio;
	scd_pkg::scd_src_t      cand;

	// two-bit fields gathered from their loose control bits
	assign detect_field = {detect_enable_high_bit, detect_enable_low_bit};
	assign gating_field = {wait_gating_high_bit, wait_gating_low_bit};

	// level of a source as seen after the synchroniser
	function automatic logic src_level(input scd_pkg::scd_src_t s,
	                                   input logic [4:0] sy,
	                                   input logic onchip);
		logic r;
		r = 1'b0;
		case (s)
			scd_pkg::SCD_SRC_MAIN:   r = sy[`SCD_OSC_MAIN];
			scd_pkg::SCD_SRC_SUB:    r = sy[`SCD_OSC_SUB];
			scd_pkg::SCD_SRC_ONCHIP: r = onchip;
			default:                 r = 1'b0;
		endcase
		return r;
	endfunction : src_level

	// cpu ratio from the divide-by-8 bit and the two-bit field
	// a new ratio waits for the channel's period boundary
	always_comb begin
		if (q.div8) begin
			cpu_ratio = `SCD_RATIO_8;
		end else begin
			case (q.cpu_div)
				2'h0:    cpu_ratio = `SCD_RATIO_1;
				2'h1:    cpu_ratio = `SCD_RATIO_2;
				2'h2:    cpu_ratio = `SCD_RATIO_4;
				2'h3:    cpu_ratio = `SCD_RATIO_16;
				default: cpu_ratio = `SCD_RATIO_1;
			endcase
		end
	end

	// high-speed field 000..111 gives ratio 2..9
	assign fast_ratio = 8'({5'h00, high_speed_divide_field} +
	                       `SCD_FAST_OFFSET);

	// on-chip clock: high-speed divided path or low-speed oscillator
	// one channel serves both uses, so they cannot drift apart
	assign onchip_lvl = ch_out[`SCD_CH_GENERAL];

	// main state update
	always_comb begin
		d = q;
		d.sync1 = {watchdog_osc_clock, high_speed_osc_clock,
		           sub_crystal_clock, low_speed_osc_clock,
		           main_crystal_clock};
		// each oscillator lands on its own synchroniser bit
		d.sync1[`SCD_OSC_MAIN] = main_crystal_clock;
		d.sync1[`SCD_OSC_SUB]  = sub_crystal_clock;
		d.sync1[`SCD_OSC_LS]   = low_speed_osc_clock;
		d.sync1[`SCD_OSC_HS]   = high_speed_osc_clock;
		d.sync1[`SCD_OSC_WDT]  = watchdog_osc_clock;
		// only the second stage is read; the first may be metastable
		d.sync2 = q.sync1;
		d.main_prev = q.sync2[`SCD_OSC_MAIN];
		main_rise = q.sync2[`SCD_OSC_MAIN] & ~q.main_prev;
		d.wait_prev = wait_mode;
		wait_rise = wait_mode & ~q.wait_prev;

		// software writes; hardware sets below take priority
		if (ctl_wr) begin
			d.div8 = wr_div8_select_bit;
			d.cpu_div = {wr_cpu_divider_high_bit, wr_cpu_divider_low_bit};
			d.onchip_sel = wr_onchip_select_flag;
			d.xtal_stopped = wr_crystal_stopped_flag;
			d.lso_stop = wr_low_speed_osc_stop_bit;
		end

		// wait entry: optional undivided wake, and latch of the tap gating
		if (wait_rise) begin
			if (wake_divider_override_bit) begin
				d.div8 = 1'b0;
				d.cpu_div = 2'h0;
			end
			d.wait_gate = (gating_field != 2'h0);
		end else if (!wait_mode) begin
			d.wait_gate = 1'b0;
		end
		// stop entry comes last so it wins over a same-cycle write
		if (stop_enter) begin
			d.div8 = 1'b1;
		end

		// stop detection watches the crystal only while it drives the cpu
		detect_on = (detect_field == `SCD_DETECT_ON) &&
		            (q.sys_sel == scd_pkg::SCD_SRC_MAIN) && !q.onchip_sel;
		// the count saturates, so a dead crystal fires only once
		stop_fire = 1'b0;
		if (!detect_on || main_rise) begin
			d.stop_cnt = 8'h00;
		end else if (q.stop_cnt != 8'(`SCD_STOP_TIMEOUT_CYC)) begin
			d.stop_cnt = 8'(q.stop_cnt + 8'h01);
			stop_fire = (q.stop_cnt == 8'(`SCD_STOP_TIMEOUT_CYC - 1));
		end
		if (stop_fire) begin
			d.onchip_sel = 1'b1;
			d.xtal_stopped = 1'b1;
			d.lso_stop = 1'b0;
		end
		// looks at the next value, so a same-cycle write of 1 is refused
		if (d.onchip_sel) begin
			d.lso_stop = 1'b0;
		end

		// shared interrupt source indication
		d.irq = d.xtal_stopped ||
		        ((detect_field == `SCD_DETECT_ON) && d.onchip_sel);

		// source change waits until both clocks are low, or the old one died
		// the sub crystal outranks the on-chip fallback
		if (sub_clock_select_bit) begin
			cand = scd_pkg::SCD_SRC_SUB;
		end else if (q.onchip_sel) begin
			cand = scd_pkg::SCD_SRC_ONCHIP;
		end else begin
			cand = scd_pkg::SCD_SRC_MAIN;
		end
		old_lvl = src_level(q.sys_sel, q.sync2, onchip_lvl);
		new_lvl = src_level(cand, q.sync2, onchip_lvl);
		if (cand != q.sys_sel && !new_lvl &&
		    (!old_lvl || q.xtal_stopped)) begin
			d.sys_sel = cand;
		end

		// crystal pins are ports only with the crystal stopped and unused
		d.port_avail = main_crystal_stop_bit &&
		               !crystal_pin_mode_bit;
	end

	// reset: low-speed on-chip oscillator, undivided
	// the stop counter starts clear, so no event can follow reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{sync1: 5'h00, sync2: 5'h00, main_prev: 1'b0,
			       sys_sel: scd_pkg::SCD_SRC_ONCHIP,
			       div8: `SCD_RST_DIV8, cpu_div: `SCD_RST_CPU_DIV,
			       lso_stop: `SCD_RST_LSO_STOP,
			       onchip_sel: `SCD_RST_ONCHIP_SEL,
			       xtal_stopped: `SCD_RST_XTAL_STOP,
			       wait_prev: 1'b0, wait_gate: 1'b0, stop_cnt: 8'h00,
			       irq: 1'b0, port_avail: 1'b0};
		end else begin
			q <= d;
		end
	end

	// channel sources, ratios and run enables
	always_comb begin
		ch_src = '0;
		ch_run = '0;
		for (int i = 0; i < `SCD_NUM_CH; i++) begin
			ch_ratio[i] = `SCD_RATIO_1;
		end
		// the cpu clock runs on in wait; the cpu is gated outside
		ch_src[`SCD_CH_CPU] = src_level(q.sys_sel, q.sync2, onchip_lvl);
		ch_ratio[`SCD_CH_CPU] = cpu_ratio;
		ch_run[`SCD_CH_CPU] = 1'b1;
		// peripheral taps share the system clock and the wait gating
		for (int i = `SCD_CH_F1; i <= `SCD_CH_F32; i++) begin
			ch_src[i] = ch_src[`SCD_CH_CPU];
			ch_run[i] = ~q.wait_gate;
		end
		ch_ratio[`SCD_CH_F1] = `SCD_RATIO_1;
		ch_ratio[`SCD_CH_F2] = `SCD_RATIO_2;
		ch_ratio[`SCD_CH_F4] = `SCD_RATIO_4;
		ch_ratio[`SCD_CH_F8] = `SCD_RATIO_8;
		ch_ratio[`SCD_CH_F32] = `SCD_RATIO_32;
		// high-speed clocks ignore wait mode, gated by the enable only
		ch_src[`SCD_CH_FAST] = q.sync2[`SCD_OSC_HS];
		ch_ratio[`SCD_CH_FAST] = fast_ratio;
		ch_run[`SCD_CH_FAST] = high_speed_osc_enable_bit;
		ch_src[`SCD_CH_HSTIMER] = q.sync2[`SCD_OSC_HS];
		ch_run[`SCD_CH_HSTIMER] = high_speed_osc_enable_bit;
		ch_src[`SCD_CH_SLOW] = q.sync2[`SCD_OSC_LS];
		ch_run[`SCD_CH_SLOW] = ~q.lso_stop;
		ch_src[`SCD_CH_GENERAL] = onchip_osc_select_bit ?
		                          ch_out[`SCD_CH_FAST] :
		                          q.sync2[`SCD_OSC_LS];
		ch_run[`SCD_CH_GENERAL] = 1'b1;
		ch_src[`SCD_CH_CAP128] = div128_source_bit ?
		                         ch_out[`SCD_CH_FAST] :
		                         ch_out[`SCD_CH_SLOW];
		ch_ratio[`SCD_CH_CAP128] = `SCD_RATIO_128;
		ch_run[`SCD_CH_CAP128] = 1'b1;
		// no other term may stop the watchdog clock in protection mode
		ch_src[`SCD_CH_WDT] = q.sync2[`SCD_OSC_WDT];
		ch_run[`SCD_CH_WDT] = count_source_protection_bit;
	end

	// one divider per output clock
	// each channel retimes its source, so every clock leaves a flip-flop
	for (genvar g = 0; g < `SCD_NUM_CH; g++) begin : g_ch
		scd_clk_div u_div (
			.sys_clk (sys_clk),
			.reset_n (reset_n),
			.src_lvl (ch_src[g]),
			.ratio   (ch_ratio[g]),
			.run     (ch_run[g]),
			.clk_out (ch_out[g])
		);
	end

	// outputs, all from flip-flops
	assign cpu_clock                 = ch_out[`SCD_CH_CPU];
	assign peripheral_divided_clock  = ch_out[`SCD_CH_F32:`SCD_CH_F1];
	assign general_onchip_clock      = ch_out[`SCD_CH_GENERAL];
	assign high_speed_timer_clock    = ch_out[`SCD_CH_HSTIMER];
	assign fast_divided_onchip_clock = ch_out[`SCD_CH_FAST];
	assign slow_onchip_clock         = ch_out[`SCD_CH_SLOW];
	assign capture_div128_clock      = ch_out[`SCD_CH_CAP128];
	assign watchdog_dedicated_clock  = ch_out[`SCD_CH_WDT];
	assign div8_select_bit           = q.div8;
	assign cpu_divider_low_bit       = q.cpu_div[0];
	assign cpu_divider_high_bit      = q.cpu_div[1];
	assign low_speed_osc_stop_bit    = q.lso_stop;
	assign onchip_select_flag        = q.onchip_sel;
	assign crystal_stopped_flag      = q.xtal_stopped;
	assign stop_detect_irq           = q.irq;
	assign port_pins_available       = q.port_avail;

endmodule : scd_clock_ctrl
`default_nettype wire

/* File: scd_map.svh */
// constants of the system clock divider and crystal stop detector
// Notes on behaviour
// - software picks the system clock: main, sub or on-chip oscillator
// - cpu clock is system clock divided by 1, 2, 4, 8 or 16
// - with divide-by-8 off, divider field 00/01/10/11 gives 1/2/4/16
// - after reset the cpu runs from the low-speed oscillator, undivided
// - entering stop mode forces the divide-by-8 select bit to one
// - peripheral taps are system clock divided by 1, 2, 4, 8 and 32
// - gating field nonzero at wait entry stops the peripheral taps in wait
// - general on-chip clock follows osc select; high-speed path divided
// - high-speed timer clock runs undivided only with high-speed enable
// - fast divided clock is high-speed osc over 2 to 9, enable gated
// - slow on-chip clock runs from low-speed osc while its stop bit is 0
// - capture clock is slow (source 0) or fast (source 1) clock over 128
// - watchdog clock runs only with source protection, never stopped
// - crystal stop detection is active only with enable field 11
// - stop: on-chip select, stopped flag, low-speed osc on, interrupt
// - with on-chip selected, low-speed stop bit reads 0, ignores a 1
// - interrupt: stopped flag, or enable 11 with on-chip select set
// - crystal pins are port pins only while the main crystal is unused
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// channel indices of the divider bank
`define SCD_CH_CPU      0
`define SCD_CH_F1       1
`define SCD_CH_F2       2
`define SCD_CH_F4       3
`define SCD_CH_F8       4
`define SCD_CH_F32      5
`define SCD_CH_FAST     6
`define SCD_CH_HSTIMER  7
`define SCD_CH_SLOW     8
`define SCD_CH_GENERAL  9
`define SCD_CH_CAP128   10
`define SCD_CH_WDT      11
`define SCD_NUM_CH      12

// synchroniser bit positions of the oscillator inputs
`define SCD_OSC_MAIN    0
`define SCD_OSC_SUB     1
`define SCD_OSC_LS      2
`define SCD_OSC_HS      3
`define SCD_OSC_WDT     4

// division ratios
`define SCD_RATIO_1     8'h01
`define SCD_RATIO_2     8'h02
`define SCD_RATIO_4     8'h04
`define SCD_RATIO_8     8'h08
`define SCD_RATIO_16    8'h10
`define SCD_RATIO_32    8'h20
`define SCD_RATIO_128   8'h80
`define SCD_FAST_OFFSET 8'h02

// reset values
`define SCD_RST_DIV8        1'h0
`define SCD_RST_CPU_DIV     2'h0
`define SCD_RST_LSO_STOP    1'h0
`define SCD_RST_ONCHIP_SEL  1'h1
`define SCD_RST_XTAL_STOP   1'h0

// detection field value that arms the detector
`define SCD_DETECT_ON       2'h3

// stop detection timeout: two periods of the slowest legal crystal
`define SCD_SYS_CLK_PERIOD_NS 25
`define SCD_STOP_TIMEOUT_NS   1000
`define SCD_STOP_TIMEOUT_CYC \
	((`SCD_STOP_TIMEOUT_NS) / (`SCD_SYS_CLK_PERIOD_NS))

`endif

/* File: scd_pkg.sv */
// types of the system clock divider and crystal stop detector
`default_nettype none
package scd_pkg;

	// system clock source
	typedef enum logic [1:0] {
		SCD_SRC_MAIN   = 2'b00,
		SCD_SRC_SUB    = 2'b01,
		SCD_SRC_ONCHIP = 2'b10
	} scd_src_t;

	// state of one glitch-free divider channel
	typedef struct packed {
		logic       prev;
		logic [7:0] cnt;
		logic [7:0] ratio;
		logic       run;
		logic       out;
	} scd_div_state_t;

	// state of the control block
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic       main_prev;
		scd_src_t   sys_sel;
		logic       div8;
		logic [1:0] cpu_div;
		logic       lso_stop;
		logic       onchip_sel;
		logic       xtal_stopped;
		logic       wait_prev;
		logic       wait_gate;
		logic [7:0] stop_cnt;
		logic       irq;
		logic       port_avail;
	} scd_state_t;

endpackage : scd_pkg
`default_nettype wire

/* File: scd_clk_div.sv */
// glitch-free divider channel clocked by sys_clk, counting source rises
`default_nettype none
module scd_clk_div (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// source and control
	input  wire logic       src_lvl,
	input  wire logic [7:0] ratio,
	input  wire logic       run,
	// divided clock
	output logic            clk_out
);

	scd_pkg::scd_div_state_t q;
	scd_pkg::scd_div_state_t d;
	logic                    rise;
	logic [8:0]              half;

	// ratio and run are taken only at a period boundary, so no pulse is cut
	always_comb begin
		d = q;
		d.prev = src_lvl;
		rise = src_lvl & ~q.prev;
		if (rise) begin
			if (q.cnt >= 8'(q.ratio - 8'h01)) begin
				d.cnt = 8'h00;
				d.ratio = (ratio == 8'h00) ? 8'h01 : ratio;
				d.run = run;
			end else begin
				d.cnt = 8'(q.cnt + 8'h01);
			end
		end
		half = 9'({1'b0, d.ratio} + 9'h001) >> 1;
		// undivided follows the source; divided is high for the first half
		if (d.ratio == 8'h01) begin
			d.out = src_lvl & d.run;
		end else begin
			d.out = d.run & ({1'b0, d.cnt} < half);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{prev: 1'b0, cnt: 8'h00, ratio: 8'h01, run: 1'b0,
			       out: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign clk_out = q.out;

endmodule : scd_clk_div
`default_nettype wire

/* File: scd_clock_ctrl_assertions.sv */
// port-level assertions on the clock control block
`default_nettype none
module scd_clock_ctrl_chk (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       reset_n,
	// control inputs
	input wire logic       ctl_wr,
	input wire logic       wr_div8_select_bit,
	input wire logic       wr_cpu_divider_low_bit,
	input wire logic       wr_cpu_divider_high_bit,
	input wire logic       stop_enter,
	input wire logic       high_speed_osc_enable_bit,
	input wire logic       detect_enable_low_bit,
	input wire logic       detect_enable_high_bit,
	// outputs watched
	input wire logic       high_speed_timer_clock,
	input wire logic       fast_divided_onchip_clock,
	input wire logic       div8_select_bit,
	input wire logic       cpu_divider_low_bit,
	input wire logic       cpu_divider_high_bit,
	input wire logic       low_speed_osc_stop_bit,
	input wire logic       onchip_select_flag,
	input wire logic       crystal_stopped_flag,
	input wire logic       stop_detect_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic [1:0] det;
	logic [7:0] hs_off_q;
	logic [7:0] hs_off_d;
	assign det = {detect_enable_high_bit, detect_enable_low_bit};
	// cycles spent with the fast oscillator off; saturates to stay sticky
	always_comb begin
		hs_off_d = hs_off_q;
		if (high_speed_osc_enable_bit)
			hs_off_d = 8'h00;
		else if (hs_off_q != 8'hff)
			hs_off_d = hs_off_q + 8'h01;
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			hs_off_q <= 8'h00;
		else
			hs_off_q <= hs_off_d;
	end
	stop_div8_a: assert property (
		stop_enter |=> div8_select_bit)
		else $error("divide-by-8 not forced at stop entry");
	write_div_a: assert property (
		ctl_wr && !stop_enter |=> div8_select_bit == $past(wr_div8_select_bit)
		&& cpu_divider_low_bit == $past(wr_cpu_divider_low_bit)
		&& cpu_divider_high_bit == $past(wr_cpu_divider_high_bit))
		else $error("cpu divider bits do not hold the written value");
	lso_zero_a: assert property (
		onchip_select_flag |-> !low_speed_osc_stop_bit)
		else $error("low-speed stop bit set while on-chip selected");
	irq_hold_a: assert property (
		crystal_stopped_flag |-> stop_detect_irq)
		else $error("interrupt low while crystal stop flag set");
	irq_clear_a: assert property (
		det != 2'h3 && !crystal_stopped_flag ##1
		det != 2'h3 && !crystal_stopped_flag |-> !stop_detect_irq)
		else $error("interrupt high without a source");
	detect_set_a: assert property (
		$rose(crystal_stopped_flag) |-> onchip_select_flag
		&& !low_speed_osc_stop_bit && stop_detect_irq)
		else $error("incomplete reaction to crystal stop");
	detect_arm_a: assert property (
		$rose(crystal_stopped_flag) |-> $past(det) == 2'h3)
		else $error("crystal stop flagged while detection disarmed");
	onchip_set_a: assert property (
		$rose(onchip_select_flag) && !$past(ctl_wr) |-> crystal_stopped_flag)
		else $error("on-chip select set without a detected stop");
	hs_gate_a: assert property (
		hs_off_q == 8'hff |-> !high_speed_timer_clock
		&& !fast_divided_onchip_clock)
		else $error("fast oscillator clocks run while disabled");
endmodule : scd_clock_ctrl_chk
bind scd_clock_ctrl scd_clock_ctrl_chk u_scd_clock_ctrl_chk (.*);
`default_nettype wire

/* File: scd_cpu_model.sv */
// cpu-side consumer that times the cpu clock between rising edges
`default_nettype none
module scd_cpu_model (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// consumed clock and its last period in sys_clk cycles
	input  wire logic        cpu_clock,
	output var  logic [15:0] cpu_period
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        prev;
	logic [15:0] cnt;
	// a rise closes one period and restarts the count
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev <= 1'b0;
			cnt <= 16'h0000;
			cpu_period <= 16'h0000;
		end else begin
			prev <= cpu_clock;
			cnt <= (cpu_clock && !prev) ? 16'h0001 : cnt + 16'h0001;
			if (cpu_clock && !prev)
				cpu_period <= cnt;
		end
	end
endmodule : scd_cpu_model
`default_nettype wire

/* File: tb_scd_clock_ctrl.sv */
// self-checking bench of the clock control block
`default_nettype none
module tb_scd_clock_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, reset_n, ctl_wr, stop_enter, wait_mode, main_run, main_tgl;
	logic main_crystal_clock, sub_crystal_clock, low_speed_osc_clock;
	logic high_speed_osc_clock, watchdog_osc_clock, wr_div8_select_bit;
	logic wr_cpu_divider_low_bit, wr_cpu_divider_high_bit;
	logic wr_low_speed_osc_stop_bit, wr_onchip_select_flag;
	logic wr_crystal_stopped_flag, sub_clock_select_bit, main_crystal_stop_bit;
	logic crystal_pin_mode_bit, sub_crystal_stop_bit, wake_divider_override_bit;
	logic wait_gating_low_bit, wait_gating_high_bit, high_speed_osc_enable_bit;
	logic onchip_osc_select_bit, div128_source_bit, count_source_protection_bit;
	logic detect_enable_low_bit, detect_enable_high_bit;
	logic cpu_clock, general_onchip_clock, high_speed_timer_clock;
	logic fast_divided_onchip_clock, slow_onchip_clock, capture_div128_clock;
	logic watchdog_dedicated_clock, div8_select_bit, cpu_divider_low_bit;
	logic cpu_divider_high_bit, low_speed_osc_stop_bit, onchip_select_flag;
	logic crystal_stopped_flag, stop_detect_irq, port_pins_available;
	logic [2:0]  high_speed_divide_field;
	logic [4:0]  peripheral_divided_clock;
	logic [11:0] sig;
	logic [15:0] cpu_per;
	logic [5:0]  wtab [5] = '{6'h02, 6'h0a, 6'h12, 6'h1a, 6'h22};
	int          rtab [5] = '{1, 2, 4, 16, 8};
	int          ttab [5] = '{1, 2, 4, 8, 32};
	int          err_count, n_tests, per, n;

	scd_clock_ctrl u_scd_clock_ctrl (.*);
	scd_cpu_model u_scd_cpu_model (.sys_clk, .reset_n, .cpu_clock,
		.cpu_period(cpu_per));

	// clocks under measurement, listed from index 11 down to 0
	assign sig = {cpu_clock, peripheral_divided_clock, general_onchip_clock,
		high_speed_timer_clock, fast_divided_onchip_clock, slow_onchip_clock,
		capture_div128_clock, watchdog_dedicated_clock};
	assign main_crystal_clock = main_run & main_tgl;

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// oscillators offset from sys_clk edges; main runs at 10 MHz
	initial begin
		{main_tgl, sub_crystal_clock, low_speed_osc_clock} = 3'h0;
		{high_speed_osc_clock, watchdog_osc_clock} = 2'h0;
		#7;
		fork
			forever #50 main_tgl = ~main_tgl;
			forever #150 sub_crystal_clock = ~sub_crystal_clock;
			forever #100 low_speed_osc_clock = ~low_speed_osc_clock;
			forever #50 high_speed_osc_clock = ~high_speed_osc_clock;
			forever #100 watchdog_osc_clock = ~watchdog_osc_clock;
		join
	end

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
		#2;
	endtask : cyc

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one control write: {div8, divider hi, lo, lso stop, onchip, stopped}
	task automatic wr(input logic [5:0] v);
		{wr_div8_select_bit, wr_cpu_divider_high_bit, wr_cpu_divider_low_bit,
		 wr_low_speed_osc_stop_bit, wr_onchip_select_flag,
		 wr_crystal_stopped_flag} = v;
		ctl_wr = 1'b1;
		cyc(1);
		ctl_wr = 1'b0;
		cyc(2);
	endtask : wr

	// period between two rises of sig[k]; 0 when the clock stands still
	task automatic meas(input int k, output int p);
		int c;
		p = 0;
		for (int r = 0; r < 2; r++) begin
			c = 0;
			while (sig[k] !== 1'b0 && c < 1600) begin
				cyc(1);
				c++;
			end
			while (sig[k] !== 1'b1 && c < 1600) begin
				cyc(1);
				c++;
			end
			p = (c < 1600) ? c : 0;
		end
	endtask : meas

	task automatic finish_test;
		if (err_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// hang guard, well above the expected run of some 35k cycles
	initial begin
		cyc(60000);
		err_count++;
		finish_test();
	end

	initial begin
		{err_count, n_tests} = '0;
		{ctl_wr, stop_enter, wait_mode, main_run, reset_n} = '0;
		{wr_div8_select_bit, wr_cpu_divider_low_bit, wr_cpu_divider_high_bit,
		 wr_low_speed_osc_stop_bit, wr_onchip_select_flag,
		 wr_crystal_stopped_flag} = '0;
		{sub_clock_select_bit, main_crystal_stop_bit, crystal_pin_mode_bit,
		 sub_crystal_stop_bit, wake_divider_override_bit, wait_gating_low_bit,
		 wait_gating_high_bit, high_speed_osc_enable_bit, onchip_osc_select_bit,
		 div128_source_bit, count_source_protection_bit, detect_enable_low_bit,
		 detect_enable_high_bit, high_speed_divide_field} = '0;
		cyc(10);
		reset_n = 1'b1;
		cyc(2);
		chk("onchip_sel", onchip_select_flag, 16'h1);
		chk("div_bits", {div8_select_bit, cpu_divider_high_bit,
			cpu_divider_low_bit}, 16'h0);
		cyc(40);
		chk("cpu_per_rst", cpu_per, 16'h8);
		meas(2, per);
		chk("slow_on", 16'(per), 16'h8);
		// every divider code, then divide-by-8; source period is 8 cycles
		for (int i = 0; i < 5; i++) begin
			wr(wtab[i]);
			cyc(400);
			chk("cpu_per", cpu_per, 16'(8 * rtab[i]));
		end
		wr(6'h02);
		cyc(100);
		for (int i = 0; i < 5; i++) begin
			meas(6 + i, per);
			chk("tap_per", 16'(per), 16'(8 * ttab[i]));
		end
		// wake override stays 0 around stop entry
		stop_enter = 1'b1;
		cyc(1);
		stop_enter = 1'b0;
		cyc(1);
		chk("div8_stop", div8_select_bit, 16'h1);
		wr(6'h02);
		high_speed_osc_enable_bit = 1'b1;
		high_speed_divide_field = 3'h1;
		for (int g = 0; g < 4; g++) begin
			{wait_gating_high_bit, wait_gating_low_bit} = 2'(g);
			cyc(2);
			wait_mode = 1'b1;
			cyc(100);
			meas(7, per);
			chk("tap_wait", 16'(per), (g == 0) ? 16'h10 : 16'h0);
			meas(4, per);
			chk("hst_wait", 16'(per), 16'h4);
			meas(5, per);
			chk("gen_wait", 16'(per), 16'h8);
			wait_mode = 1'b0;
			cyc(50);
		end
		{wait_gating_high_bit, wait_gating_low_bit} = 2'h0;
		// wait entry keeps divide-by-8 unless the wake override is set
		wr(6'h22);
		for (int w = 0; w < 2; w++) begin
			{wake_divider_override_bit, wait_mode} = {1'(w), 1'b1};
			cyc(2);
			chk("wake_div8", div8_select_bit, 16'(1 - w));
			{wake_divider_override_bit, wait_mode} = 2'h0;
			cyc(2);
		end
		onchip_osc_select_bit = 1'b1;
		cyc(100);
		meas(5, per);
		chk("gen_fast", 16'(per), 16'hc);
		meas(3, per);
		chk("fast_per", 16'(per), 16'hc);
		meas(1, per);
		chk("cap_slow", 16'(per), 16'h400);
		div128_source_bit = 1'b1;
		cyc(1100);
		meas(1, per);
		chk("cap_fast", 16'(per), 16'h600);
		high_speed_divide_field = 3'h7;
		cyc(100);
		meas(3, per);
		chk("fast_per9", 16'(per), 16'h24);
		onchip_osc_select_bit = 1'b0;
		cyc(100);
		high_speed_osc_enable_bit = 1'b0;
		cyc(100);
		meas(4, per);
		chk("hst_off", 16'(per), 16'h0);
		meas(3, per);
		chk("fast_off", 16'(per), 16'h0);
		count_source_protection_bit = 1'b1;
		cyc(50);
		meas(0, per);
		chk("wdt_on", 16'(per), 16'h8);
		count_source_protection_bit = 1'b0;
		cyc(50);
		meas(0, per);
		chk("wdt_off", 16'(per), 16'h0);
		main_crystal_stop_bit = 1'b1;
		cyc(3);
		chk("ports_free", port_pins_available, 16'h1);
		crystal_pin_mode_bit = 1'b1;
		main_crystal_stop_bit = 1'b0;
		cyc(3);
		chk("ports_xtal", port_pins_available, 16'h0);
		wr(6'h06);
		chk("lso_refuse", low_speed_osc_stop_bit, 16'h0);
		sub_crystal_stop_bit = 1'b1;
		cyc(2);
		sub_crystal_stop_bit = 1'b0;
		sub_clock_select_bit = 1'b1;
		cyc(200);
		chk("cpu_sub", cpu_per, 16'hc);
		sub_clock_select_bit = 1'b0;
		main_run = 1'b1;
		cyc(100);
		wr(6'h00);
		cyc(60);
		chk("cpu_main", cpu_per, 16'h4);
		wr(6'h04);
		cyc(50);
		meas(2, per);
		chk("slow_off", 16'(per), 16'h0);
		{detect_enable_high_bit, detect_enable_low_bit} = 2'h2;
		cyc(2);
		main_run = 1'b0;
		cyc(100);
		chk("unarmed", onchip_select_flag, 16'h0);
		main_run = 1'b1;
		cyc(20);
		// low-speed fallback: select bit already 0 before arming
		{detect_enable_high_bit, detect_enable_low_bit} = 2'h3;
		cyc(3);
		chk("irq_idle", stop_detect_irq, 16'h0);
		main_run = 1'b0;
		n = 0;
		while (onchip_select_flag !== 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		chk("stop_flags", {onchip_select_flag, crystal_stopped_flag,
			low_speed_osc_stop_bit, stop_detect_irq}, 16'hd);
		cyc(60);
		chk("cpu_fallback", cpu_per, 16'h8);
		wr(6'h02);
		chk("irq_onchip", stop_detect_irq, 16'h1);
		{detect_enable_high_bit, detect_enable_low_bit} = 2'h0;
		cyc(3);
		chk("irq_clear", stop_detect_irq, 16'h0);
		finish_test();
	end
endmodule : tb_scd_clock_ctrl
`default_nettype wire
